// [dv/reset_irq_fetch_status_pins_bench.sv]
// Self-checking bench for the reset, interrupt, fetch and status pin logic.
`timescale 1ns/1ps
module reset_irq_fetch_status_pins_bench;
    import rifsp_pkg::*;
    logic ref_clk = 1'b0, nrst = 1'b0;
    logic reset_in_n, nmi_in_n, branch_test_in_n;
    logic [3:0] ext_irq_lines_n, ack_code = 4'h0;
    logic deep_idle_state = 1'b0, fetch_req = 1'b0, fetch_offchip = 1'b1, ack_req = 1'b0;
    logic [15:0] fetch_addr = 16'h0000, addr_out;
    logic [2:0] wait_states = 3'h0;
    logic addr_visibility_bit = 1'b0, flag_wr = 1'b0, flag_val = 1'b0, timer_evt = 1'b0;
    logic core_reset, reset_vec_fetch, branch_test, bus_busy, core_clock_out;
    logic fetch_strobe_n, irq_ack_strobe_n, user_flag_out, timer_pulse_out;
    logic [4:0] irq_evt;
    int mismatches = 0, tests_run = 0;

    always #5 ref_clk = ~ref_clk;

    rifsp_board rifsp_board_inst (.ref_clk(ref_clk), .reset_in_n(reset_in_n),
        .ext_irq_lines_n(ext_irq_lines_n), .nmi_in_n(nmi_in_n),
        .branch_test_in_n(branch_test_in_n));

    rifsp_pins rifsp_pins_inst (.ref_clk(ref_clk), .nrst(nrst), .reset_in_n(reset_in_n),
        .ext_irq_lines_n(ext_irq_lines_n), .nmi_in_n(nmi_in_n),
        .branch_test_in_n(branch_test_in_n), .deep_idle_state(deep_idle_state),
        .fetch_req(fetch_req), .fetch_offchip(fetch_offchip), .fetch_addr(fetch_addr),
        .ack_req(ack_req), .ack_code(ack_code), .wait_states(wait_states),
        .addr_visibility_bit(addr_visibility_bit), .flag_wr(flag_wr), .flag_val(flag_val),
        .timer_evt(timer_evt), .core_reset(core_reset), .reset_vec_fetch(reset_vec_fetch),
        .irq_evt(irq_evt), .branch_test(branch_test), .bus_busy(bus_busy),
        .core_clock_out(core_clock_out), .fetch_strobe_n(fetch_strobe_n),
        .irq_ack_strobe_n(irq_ack_strobe_n), .addr_out(addr_out),
        .user_flag_out(user_flag_out), .timer_pulse_out(timer_pulse_out));

    // ****************************************************************
    // Shared tasks.
    // ****************************************************************
    task automatic step();
        @(posedge ref_clk) #1;
    endtask

    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic report_and_stop();
        $display("counts: %0d compared, %0d mismatched", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // ****************************************************************
    // Scenarios.
    // ****************************************************************
    task automatic test_reset_release();
        int n = 0;
        rifsp_board_inst.set_reset(1'b1);
        while (core_reset !== 1'b0 && n < 40) begin n++; step(); end
        n = 0;
        while (reset_vec_fetch !== 1'b1 && n < 100) begin n++; step(); end
        chk("reset_to_vector", 16'(n), 16'(RST_FETCH_CYC));
        step();
        chk("vector_addr", addr_out, RESET_VEC_ADDR);
        repeat (4) step();
        $display("test reset_release done");
    endtask

    task automatic test_pin_reset();
        rifsp_board_inst.set_reset(1'b0);
        repeat (16) step();
        chk("pin_reset", 16'(core_reset), 16'h0001);
        test_reset_release();
    endtask

    // One bus cycle: strobe width, address and busy length.
    task automatic bus_op(input logic ack, input logic [2:0] ws, input logic off,
                          input logic [15:0] a, input logic [15:0] exp_addr);
        int n = 1;
        fetch_offchip = off;
        fetch_addr = a;
        wait_states = ws;
        if (ack) ack_req = 1'b1;
        else fetch_req = 1'b1;
        step();
        fetch_req = 1'b0;
        ack_req = 1'b0;
        chk("fetch_strobe", 16'(fetch_strobe_n), 16'(ack));
        chk("ack_strobe", 16'(irq_ack_strobe_n), 16'(!ack));
        chk("bus_addr", addr_out, exp_addr);
        step();
        chk("strobes_high", 16'({fetch_strobe_n, irq_ack_strobe_n}), 16'h0003);
        while (bus_busy === 1'b1 && n < 40) begin n++; step(); end
        chk("busy_len", 16'(n), 16'(2 * (ws + 1)));
    endtask

    task automatic test_bus();
        for (int ws = 0; ws < 8; ws += 3) begin
            bus_op(1'b0, 3'(ws), 1'b1, 16'h1234 + 16'(ws), 16'h1234 + 16'(ws));
        end
        ack_code = 4'ha;
        bus_op(1'b1, 3'h2, 1'b1, 16'h0ff1, 16'h0ff5);
        addr_visibility_bit = 1'b1;
        bus_op(1'b0, 3'h0, 1'b0, 16'h0042, 16'h0ff5);
        bus_op(1'b0, 3'h1, 1'b1, 16'h8001, 16'h8001);
        addr_visibility_bit = 1'b0;
        bus_op(1'b0, 3'h0, 1'b0, 16'h0042, 16'h0042);
        $display("test bus done");
    endtask

    task automatic irq_case(input int idx, input int lo, input logic idle, input int exp);
        int cnt = 0;
        deep_idle_state = idle;
        fork
            rifsp_board_inst.pulse(idx, lo);
            repeat (lo + 30) begin step(); cnt += int'(irq_evt[idx] === 1'b1); end
        join
        chk("irq_events", 16'(cnt), 16'(exp));
    endtask

    task automatic test_irq();
        for (int i = 0; i < 5; i++) irq_case(i, 6, 1'b0, 1);
        irq_case(1, 2, 1'b0, 0);
        irq_case(4, 6, 1'b1, 0);
        irq_case(2, 12, 1'b1, 1);
        deep_idle_state = 1'b0;
        $display("test irq done");
    endtask

    task automatic test_status();
        int n = 0;
        rifsp_board_inst.set_branch(1'b0);
        repeat (8) step();
        chk("branch_low", 16'(branch_test), 16'h0000);
        rifsp_board_inst.set_branch(1'b1);
        repeat (8) step();
        chk("branch_high", 16'(branch_test), 16'h0001);
        for (int v = 1; v >= 0; v--) begin
            flag_val = 1'(v);
            flag_wr = 1'b1;
            step();
            flag_wr = 1'b0;
            chk("user_flag", 16'(user_flag_out), 16'(v));
        end
        timer_evt = 1'b1;
        step();
        timer_evt = 1'b0;
        while (timer_pulse_out !== 1'b1 && n < 6) begin n++; step(); end
        chk("timer_on_fall", 16'(core_clock_out), 16'h0000);
        n = 0;
        while (timer_pulse_out === 1'b1 && n < 9) begin n++; step(); end
        chk("timer_width", 16'(n), 16'(TIMER_PULSE_OUT_CYC));
        $display("test status done");
    endtask

    // ****************************************************************
    // Main sequence and watchdog.
    // ****************************************************************
    initial begin
        repeat (6) @(posedge ref_clk);
        #1 nrst = 1'b1;
        test_reset_release();
        test_bus();
        test_irq();
        test_status();
        test_pin_reset();
        report_and_stop();
    end

    initial begin
        #20000;
        mismatches++;
        report_and_stop();
    end
endmodule // reset_irq_fetch_status_pins_bench

// [dv/rifsp_board.sv]
// Board-side model that drives the reset, interrupt and branch-test pins.
`timescale 1ns/1ps
module rifsp_board
    import rifsp_pkg::*;
(
    // Clock.
    input  wire logic                ref_clk,
    // Board pins.
    output logic                     reset_in_n,
    output logic [NUM_IRQ-1:0]       ext_irq_lines_n,
    output logic                     nmi_in_n,
    output logic                     branch_test_in_n
);
    logic [4:0] irq_n = 5'h1f;

    assign ext_irq_lines_n = irq_n[3:0];
    assign nmi_in_n        = irq_n[4];

    initial begin
        reset_in_n       = 1'b0;
        branch_test_in_n = 1'b1;
    end

    // ****************************************************************
    // Pin drivers, all changed just after a rising edge.
    // ****************************************************************
    task automatic set_reset(input logic v);
        @(posedge ref_clk) #1 reset_in_n = v;
    endtask

    task automatic set_branch(input logic v);
        @(posedge ref_clk) #1 branch_test_in_n = v;
    endtask

    // Low pulse of lo cycles, then the pin is driven high again; the caller waits out the high run so the next pulse can qualify.
    task automatic pulse(input int idx, input int lo);
        @(posedge ref_clk) #1 irq_n[idx] = 1'b0;
        repeat (lo) @(posedge ref_clk);
        #1 irq_n[idx] = 1'b1;
    endtask
endmodule // rifsp_board

// [src/rifsp_pin_filter.sv]
// Three-stage synchroniser and pulse-width qualifier for one active-low input pin.
`timescale 1ns/1ps
module rifsp_pin_filter
    import rifsp_pkg::*;
(
    // Clock and reset.
    input  wire logic   ref_clk,
    input  wire logic   nrst,
    // Raw pin.
    input  wire logic   pin_n,
    // Qualified line.
    rifsp_pin_if.filt   line
);

    logic [SYNC_STAGES-1:0] sync;
    rifsp_cnt_t             low_cnt;
    rifsp_cnt_t             high_cnt;
    logic                   high_ok;
    logic                   agree;

    assign agree = (sync[1] == sync[2]);

    // ****************************************************************
    // Synchroniser.
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sync <= 3'h7;
        end else begin
            sync <= {sync[SYNC_STAGES-2:0], pin_n};
        end
    end

    // ****************************************************************
    // Run-length qualification.
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            low_cnt    <= ZERO_CYC;
            high_cnt   <= ZERO_CYC;
            high_ok    <= 1'b1;
            line.level <= 1'b1;
            line.fall  <= 1'b0;
        end else begin
            line.fall <= 1'b0;
            if (agree) begin
                line.level <= sync[2];
                if (sync[2]) begin
                    low_cnt <= ZERO_CYC;
                    if (high_cnt != '1) begin
                        high_cnt <= high_cnt + ONE_CNT;
                    end
                    if (high_cnt + ONE_CNT >= line.high_min) begin
                        high_ok <= 1'b1;
                    end
                end else begin
                    high_cnt <= ZERO_CYC;
                    if (low_cnt != '1) begin
                        low_cnt <= low_cnt + ONE_CNT;
                    end
                    if (high_ok && (low_cnt + ONE_CNT >= line.low_min)) begin
                        line.fall <= 1'b1;
                        high_ok   <= 1'b0;
                    end
                end
            end
        end
    end

    // ****************************************************************
    // Checks.
    // ****************************************************************
    fall_synced_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        line.fall |-> $past(!sync[2] && !sync[1]))
        else $error("Line event without an agreed low synchronised level.");

endmodule // rifsp_pin_filter

// [src/rifsp_pin_if.sv]
// Connection between one pin qualifier and the control logic.
`timescale 1ns/1ps
interface rifsp_pin_if;
    import rifsp_pkg::*;
    rifsp_cnt_t low_min;
    rifsp_cnt_t high_min;
    logic       level;
    logic       fall;
    modport filt (input low_min, input high_min, output level, output fall);
    modport user (output low_min, output high_min, input level, input fall);
endinterface

// [src/rifsp_pins.sv]
// Reset, interrupt, branch-test, fetch strobe, flag and timer pin control.
`timescale 1ns/1ps
module rifsp_pins
    import rifsp_pkg::*;
(
    // Clock and reset.
    input  wire logic                ref_clk,
    input  wire logic                nrst,
    // Board pins in.
    input  wire logic                reset_in_n,
    input  wire logic [NUM_IRQ-1:0]  ext_irq_lines_n,
    input  wire logic                nmi_in_n,
    input  wire logic                branch_test_in_n,
    // Core requests.
    input  wire logic                deep_idle_state,
    input  wire logic                fetch_req,
    input  wire logic                fetch_offchip,
    input  wire logic [ADDR_W-1:0]   fetch_addr,
    input  wire logic                ack_req,
    input  wire logic [ACK_W-1:0]    ack_code,
    input  wire logic [WS_W-1:0]     wait_states,
    input  wire logic                addr_visibility_bit,
    input  wire logic                flag_wr,
    input  wire logic                flag_val,
    input  wire logic                timer_evt,
    // Core status.
    output logic                     core_reset,
    output logic                     reset_vec_fetch,
    output logic [NUM_EVT-1:0]       irq_evt,
    output logic                     branch_test,
    output logic                     bus_busy,
    // Board pins out.
    output logic                     core_clock_out,
    output logic                     fetch_strobe_n,
    output logic                     irq_ack_strobe_n,
    output logic [ADDR_W-1:0]        addr_out,
    output logic                     user_flag_out,
    output logic                     timer_pulse_out
);

    // Pulse minimums per line; deep idle lengthens the interrupt ones.
    function automatic rifsp_cnt_t line_min(input int idx, input logic low, input logic idle);
        rifsp_cnt_t base;
        base = low ? IRQ_LOW_CYC : IRQ_HIGH_CYC;
        if (idx == LINE_RST) begin
            base = low ? RST_LOW_CYC : ZERO_CYC;
        end else if (idx == LINE_BIO) begin
            base = low ? BIO_LOW_CYC : ZERO_CYC;
        end else if (idle) begin
            base = base + IDLE_CYC;
        end
        return base;
    endfunction

    logic [NUM_LINES-1:0] pins_raw;
    rifsp_pin_if          pins_if [NUM_LINES] ();

    rifsp_bus_e           state;
    rifsp_bcnt_t          bus_cnt;
    logic                 accept;
    logic                 want_fetch;
    logic                 visible;
    logic                 rel_active;
    rifsp_cnt_t           rel_cnt;
    logic                 timer_pulse_out_pend;
    rifsp_cnt_t           timer_pulse_out_cnt;

    assign pins_raw = {reset_in_n, branch_test_in_n, nmi_in_n, ext_irq_lines_n};

    // ****************************************************************
    // Pin qualifiers.
    // ****************************************************************
    generate
        for (genvar i = 0; i < NUM_LINES; i++) begin : g_line
            assign pins_if[i].low_min  = line_min(i, 1'b1, deep_idle_state);
            assign pins_if[i].high_min = line_min(i, 1'b0, deep_idle_state);
            rifsp_pin_filter u_filt (
                .ref_clk (ref_clk),
                .nrst    (nrst),
                .pin_n   (pins_raw[i]),
                .line    (pins_if[i])
            );
        end
        for (genvar j = 0; j < NUM_EVT; j++) begin : g_evt
            always_ff @(posedge ref_clk or negedge nrst) begin
                if (!nrst) begin
                    irq_evt[j] <= 1'b0;
                end else begin
                    irq_evt[j] <= pins_if[j].fall;
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Output clock and branch-test sampling.
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            core_clock_out <= 1'b0;
            branch_test    <= 1'b1;
        end else begin
            core_clock_out <= !core_clock_out;
            if (core_clock_out) begin
                branch_test <= pins_if[LINE_BIO].level;
            end
        end
    end

    // ****************************************************************
    // Reset hold and reset vector delay.
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            core_reset      <= 1'b1;
            rel_active      <= 1'b0;
            rel_cnt         <= ZERO_CYC;
            reset_vec_fetch <= 1'b0;
        end else begin
            reset_vec_fetch <= 1'b0;
            if (pins_if[LINE_RST].fall) begin
                core_reset <= 1'b1;
                rel_active <= 1'b0;
            end else if (core_reset && pins_if[LINE_RST].level) begin
                core_reset <= 1'b0;
                rel_active <= 1'b1;
                rel_cnt    <= ZERO_CYC;
            end else if (rel_active) begin
                rel_cnt <= rel_cnt + ONE_CNT;
                if (rel_cnt == RST_FETCH_CYC - ONE_CNT) begin
                    reset_vec_fetch <= 1'b1;
                    rel_active      <= 1'b0;
                end
            end
        end
    end

    // ****************************************************************
    // Bus cycle sequencing.
    // ****************************************************************
    assign want_fetch = reset_vec_fetch || fetch_req;
    assign accept     = (state == ST_IDLE) && !core_reset && (want_fetch || ack_req);
    assign visible    = reset_vec_fetch || fetch_offchip || (addr_visibility_bit == ADDR_VISIBILITY_BIT_SHOW);

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state    <= ST_IDLE;
            bus_cnt  <= '0;
            bus_busy <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (accept) begin
                        state    <= ST_STROBE;
                        bus_cnt  <= STROBE_CYC - 5'h01;
                        bus_busy <= 1'b1;
                    end
                end
                ST_STROBE: begin
                    if (bus_cnt == '0) begin
                        state   <= ST_WAIT;
                        bus_cnt <= BUS_CYC - STROBE_CYC - 5'h01
                                   + rifsp_bcnt_t'(wait_states) * BUS_CYC;
                    end else begin
                        bus_cnt <= bus_cnt - 5'h01;
                    end
                end
                ST_WAIT: begin
                    if (bus_cnt == '0) begin
                        state    <= ST_IDLE;
                        bus_busy <= 1'b0;
                    end else begin
                        bus_cnt <= bus_cnt - 5'h01;
                    end
                end
                default: begin
                    state    <= ST_IDLE;
                    bus_busy <= 1'b0;
                end
            endcase
        end
    end

    // Strobes last the first cycle only, whatever the wait count.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            fetch_strobe_n   <= 1'b1;
            irq_ack_strobe_n <= 1'b1;
        end else if (accept) begin
            fetch_strobe_n   <= !want_fetch;
            irq_ack_strobe_n <= want_fetch;
        end else if (state == ST_STROBE && bus_cnt == '0) begin
            fetch_strobe_n   <= 1'b1;
            irq_ack_strobe_n <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            addr_out <= RESET_VEC_ADDR;
        end else if (accept) begin
            if (reset_vec_fetch) begin
                addr_out <= RESET_VEC_ADDR;
            end else if (!visible) begin
                addr_out <= addr_out;
            end else if (!fetch_req) begin
                addr_out <= fetch_addr;
                addr_out[ACK_LSB +: ACK_W] <= ack_code;
            end else begin
                addr_out <= fetch_addr;
            end
        end
    end

    // ****************************************************************
    // User flag and timer pulse.
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            user_flag_out <= 1'b0;
        end else if (flag_wr) begin
            user_flag_out <= flag_val;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            timer_pulse_out <= 1'b0;
            timer_pulse_out_pend       <= 1'b0;
            timer_pulse_out_cnt        <= ZERO_CYC;
        end else if (core_clock_out && timer_pulse_out_pend && !timer_pulse_out) begin
            timer_pulse_out <= 1'b1;
            timer_pulse_out_cnt        <= TIMER_PULSE_OUT_CYC - ONE_CNT;
            timer_pulse_out_pend       <= timer_evt;
        end else begin
            timer_pulse_out_pend <= timer_pulse_out_pend || timer_evt;
            if (timer_pulse_out) begin
                if (timer_pulse_out_cnt == ZERO_CYC) begin
                    timer_pulse_out <= 1'b0;
                end else begin
                    timer_pulse_out_cnt <= timer_pulse_out_cnt - ONE_CNT;
                end
            end
        end
    end

    // ****************************************************************
    // Checks.
    // ****************************************************************
    rst_fetch_delay_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        $fell(core_reset) |-> ##34 (reset_vec_fetch || core_reset))
        else $error("Reset vector fetch not 34 half-periods after release.");
    no_early_fetch_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        $fell(core_reset) |-> !reset_vec_fetch[*8])
        else $error("Reset vector fetch too soon after release.");
    fetch_width_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        $fell(fetch_strobe_n) |=> fetch_strobe_n && bus_busy)
        else $error("Fetch strobe not a single half-period pulse.");
    ack_width_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        $fell(irq_ack_strobe_n) |=> irq_ack_strobe_n && fetch_strobe_n)
        else $error("Acknowledge strobe not a single half-period pulse.");
    wait_quiet_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (state == ST_WAIT) |-> (fetch_strobe_n && irq_ack_strobe_n))
        else $error("Strobe low during wait states.");
    ack_code_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        $fell(irq_ack_strobe_n) && $past(visible) |-> addr_out[ACK_LSB +: ACK_W] == $past(ack_code))
        else $error("Acknowledge address does not carry the interrupt code.");
    addr_hide_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        accept && !visible |=> $stable(addr_out))
        else $error("Hidden internal address driven out.");
    timer_pulse_out_edge_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        $rose(timer_pulse_out) |-> $fell(core_clock_out) ##1 timer_pulse_out ##1 !timer_pulse_out)
        else $error("Timer pulse misplaced or wrong width.");
    flag_update_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        flag_wr |=> user_flag_out == $past(flag_val))
        else $error("User flag not updated.");
    bio_sample_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        $changed(branch_test) |-> $fell(core_clock_out))
        else $error("Branch-test changed off the falling output-clock edge.");

    reset_vec_c: cover property (@(posedge ref_clk) disable iff (!nrst) reset_vec_fetch);
    ack_wait_c: cover property (@(posedge ref_clk) disable iff (!nrst)
        $fell(irq_ack_strobe_n) ##2 bus_busy);
    timer_c: cover property (@(posedge ref_clk) disable iff (!nrst) $rose(timer_pulse_out));
    irq_c: cover property (@(posedge ref_clk) disable iff (!nrst) irq_evt[0] && deep_idle_state);

endmodule // rifsp_pins

// [src/rifsp_pkg.sv]
// Shared constants and types for the reset, interrupt, fetch and status pin logic.
package rifsp_pkg;

    // ****************************************************************
    // Clock and half-period.
    // ****************************************************************
    localparam int REF_PERIOD_NS = 10;
    // The output clock toggles on every rising core edge, so its half-period equals one core period.
    localparam int H_NS          = 10;
    localparam int H_CYC         = (H_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;

    // ****************************************************************
    // Timings in half-periods or nanoseconds, as specified.
    // ****************************************************************
    localparam int RST_LOW_MIN_H  = 12;
    localparam int RST_FETCH_H    = 34;
    localparam int IRQ_LOW_MIN_H  = 4;
    localparam int IRQ_HIGH_MIN_H = 2;
    localparam int IDLE_EXTRA_H   = 4;
    localparam int BIO_LOW_MIN_NS = 15;
    localparam int TIMER_PULSE_OUT_H         = 2;
    localparam int STROBE_H       = 1;
    localparam int BUS_H          = 2;

    // ****************************************************************
    // Derived cycle counts and widths.
    // ****************************************************************
    localparam int CNT_W     = 6;
    localparam int BUS_CNT_W = 5;
    typedef logic [CNT_W-1:0]     rifsp_cnt_t;
    typedef logic [BUS_CNT_W-1:0] rifsp_bcnt_t;

    localparam rifsp_cnt_t  RST_LOW_CYC   = rifsp_cnt_t'(RST_LOW_MIN_H * H_CYC);
    localparam rifsp_cnt_t  RST_FETCH_CYC = rifsp_cnt_t'(RST_FETCH_H * H_CYC);
    localparam rifsp_cnt_t  IRQ_LOW_CYC   = rifsp_cnt_t'(IRQ_LOW_MIN_H * H_CYC);
    localparam rifsp_cnt_t  IRQ_HIGH_CYC  = rifsp_cnt_t'(IRQ_HIGH_MIN_H * H_CYC);
    localparam rifsp_cnt_t  IDLE_CYC      = rifsp_cnt_t'(IDLE_EXTRA_H * H_CYC);
    localparam rifsp_cnt_t  BIO_LOW_CYC   =
        rifsp_cnt_t'((BIO_LOW_MIN_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS);
    localparam rifsp_cnt_t  ZERO_CYC      = 6'h00;
    localparam rifsp_cnt_t  ONE_CNT       = 6'h01;
    localparam rifsp_bcnt_t STROBE_CYC    = rifsp_bcnt_t'(STROBE_H * H_CYC);
    localparam rifsp_bcnt_t BUS_CYC       = rifsp_bcnt_t'(BUS_H * H_CYC);
    localparam rifsp_cnt_t  TIMER_PULSE_OUT_CYC      = rifsp_cnt_t'(TIMER_PULSE_OUT_H * H_CYC);

    // ****************************************************************
    // Pins, lines and address fields.
    // ****************************************************************
    localparam int NUM_IRQ     = 4;
    localparam int LINE_NMI    = 4;
    localparam int LINE_BIO    = 5;
    localparam int LINE_RST    = 6;
    localparam int NUM_LINES   = 7;
    localparam int NUM_EVT     = 5;
    localparam int SYNC_STAGES = 3;
    localparam int ADDR_W      = 16;
    localparam int WS_W        = 3;
    localparam int ACK_LSB     = 1;
    localparam int ACK_W       = 4;
    localparam logic              ADDR_VISIBILITY_BIT_SHOW      = 1'h0;
    localparam logic [ADDR_W-1:0] RESET_VEC_ADDR = 16'h0000;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_STROBE = 3'b010,
        ST_WAIT   = 3'b100
    } rifsp_bus_e;

endpackage
